// ### logic/dtc_params.svh
// constants for the data-lane termination control block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define DTC_ADDR_TERM_MODE   8'h00
`define DTC_ADDR_LINK_CFG    8'h04
`define DTC_ADDR_STATUS      8'h08

// ----------------------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------------------
`define DTC_TERM_FIELD_MSB   2
`define DTC_CFG_BAND_MSB     2
`define DTC_CFG_SET_B_BIT    3
`define DTC_CFG_BL32_BIT     4
`define DTC_CFG_WLEV_BIT     5
`define DTC_CFG_MSB          5
`define DTC_ST_DQ_BIT        0
`define DTC_ST_DQS_BIT       1
`define DTC_ST_ACTIVE_BIT    2
`define DTC_ST_UNSUP_BIT     3
`define DTC_ST_ARMED_BIT     4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DTC_TERM_MODE_RST    3'h0
`define DTC_LINK_CFG_RST     6'h00

// ----------------------------------------------------------------------------
// latency tables in clocks, six bits per band, band 7 leftmost, 0 = unsupported
// ----------------------------------------------------------------------------
`define DTC_LAT_W            6
`define DTC_LON_A_TBL        48'h20_61_84_10_00_00
`define DTC_LON_B_TBL        48'h61_44_8E_30_60_00
`define DTC_LOFF_A_TBL       48'h71_A6_16_50_00_00
`define DTC_LOFF_B_TBL       48'hB2_89_20_71_60_00
`define DTC_BL32_EXTRA       6'h08

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define DTC_RESP_OKAY        2'h0
`define DTC_RESP_SLVERR      2'h2

`endif

// ### logic/dtc_pkg.sv
// types shared by the termination control modules
package dtc_pkg;

    // ------------------------------------------------------------------------
    // controller-supplied link configuration
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       wlev;      // write-leveling mode
        logic       bl32;      // burst_length 32 when set, else 16
        logic       set_b;     // write_latency_set_b when set
        logic [2:0] band;      // speed band index 0..7
    } dtc_cfg_t;

    // ------------------------------------------------------------------------
    // selected latency pair
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       ok;
        logic [5:0] on_lat;
        logic [5:0] off_lat;
    } dtc_lat_t;

    typedef enum logic [0:0] {TM_IDLE, TM_RUN} dtc_tm_state_t;

endpackage

// ### logic/dtc_lat_timer.sv
// latency timer counting clocks from the second CAS command
`timescale 1ns/100ps
`include "dtc_params.svh"

module dtc_lat_timer
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic     aclk,
    input  wire logic     aresetn,
    // start and latencies
    input  wire logic     start,
    input  wire dtc_lat_t lat,
    // status
    output logic          window,
    output logic          running
);

    dtc_tm_state_t  state_reg;
    dtc_tm_state_t  state_next;
    logic [5:0]     cnt_reg;
    logic [5:0]     cnt_next;
    dtc_lat_t       lat_reg;
    dtc_lat_t       lat_next;

    // ------------------------------------------------------------------------
    // next state: a new start restarts the count from one, so a back-to-back write
    // closes the window again until its own turn-on latency is reached
    // ------------------------------------------------------------------------
    wire   at_off = (cnt_reg == lat_reg.off_lat);
    assign lat_next   = start ? lat : lat_reg;
    assign cnt_next   = start ? 6'h01 : (state_reg == TM_RUN && !at_off) ? cnt_reg + 6'h01 : cnt_reg;
    assign state_next = start ? TM_RUN : (at_off ? TM_IDLE : state_reg);

    // on at latency, off at the off latency
    assign window  = (state_reg == TM_RUN) && lat_reg.ok && (cnt_reg >= lat_reg.on_lat) && !at_off;
    assign running = (state_reg == TM_RUN);

    // state registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= TM_IDLE;
            cnt_reg   <= 6'h00;
            lat_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            lat_reg   <= lat_next;
        end
    end

endmodule // dtc_lat_timer

// ### logic/dtc_term_ctrl.sv
// data-lane on-die termination control with an AXI4-Lite register port
// ----------------------------------------------------------------------------
// Functional notes
// - termination is enabled only while the three-bit mode field is non-zero.
// - codes 1..6 select 240, 120, 80, 60, 48 and 40 ohm and are driven out as the termination_value code.
// - with termination enabled but no write burst, the data lanes stay high impedance.
// - a write, masked write or write-fifo command arms termination, switched on without a control pin.
// - termination switches off again once the triggering burst write has completed.
// - turn-on latency is counted in clocks from the second CAS command.
// - turn-off latency is counted in clocks from the second CAS command.
// - turn-on latency per band and set is taken from the table; bands at or below 533 MHz are unsupported.
// - turn-off latency per band and set is taken from the table, plus 8 clocks for 32-beat bursts.
// - termination is off throughout power-down.
// - in self refresh termination is off while cke is low and allowed while cke is high.
// - in write leveling the strobe lanes follow the mode field continuously; data and mask lanes stay off.
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "dtc_params.svh"

module dtc_term_ctrl
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // decoded commands and device state
    input  wire logic        write_cmd,
    input  wire logic        cas2_cmd,
    input  wire logic        cke,
    input  wire logic        power_down,
    input  wire logic        self_refresh,
    // termination controls
    output logic             dq_term_en,
    output logic             dqs_term_en,
    output logic             dmi_term_en,
    output logic [2:0]       termination_value
);

    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------
    logic [2:0]  term_mode_reg;
    dtc_cfg_t    cfg_reg;
    logic        armed_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        dq_reg;
    logic        dqs_reg;
    logic [2:0]  value_reg;
    dtc_lat_t    cur_lat;
    logic        win;
    logic        t_running;

    // ------------------------------------------------------------------------
    // axi4-lite write path: address and data taken in either order
    // ------------------------------------------------------------------------
    wire aw_hs    = s_axi_awvalid && s_axi_awready;
    wire w_hs     = s_axi_wvalid && s_axi_wready;
    wire wr_do    = aw_got_reg && w_got_reg && !bvalid_reg;
    wire wr_mode  = wr_do && (awaddr_reg == `DTC_ADDR_TERM_MODE);
    wire wr_cfg   = wr_do && (awaddr_reg == `DTC_ADDR_LINK_CFG);
    wire wr_hit   = wr_mode || wr_cfg;
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // byte lane 0 holds every writable field, so only wstrb[0] matters
    wire [2:0] term_mode_next = (wr_mode && wstrb_reg[0]) ? wdata_reg[`DTC_TERM_FIELD_MSB:0] : term_mode_reg;
    wire [5:0] cfg_next       = (wr_cfg && wstrb_reg[0]) ? wdata_reg[`DTC_CFG_MSB:0] : cfg_reg;

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            bvalid_reg    <= 1'b0;
            bresp_reg     <= `DTC_RESP_OKAY;
            term_mode_reg <= `DTC_TERM_MODE_RST;
            cfg_reg       <= `DTC_LINK_CFG_RST;
        end else begin
            aw_got_reg    <= (aw_got_reg || aw_hs) && !wr_do;
            w_got_reg     <= (w_got_reg || w_hs) && !wr_do;
            awaddr_reg    <= aw_hs ? {s_axi_awaddr[7:2], 2'b00} : awaddr_reg;
            wdata_reg     <= w_hs ? s_axi_wdata : wdata_reg;
            wstrb_reg     <= w_hs ? s_axi_wstrb : wstrb_reg;
            bvalid_reg    <= wr_do || (bvalid_reg && !s_axi_bready);
            bresp_reg     <= wr_do ? (wr_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR) : bresp_reg;
            term_mode_reg <= term_mode_next;
            cfg_reg       <= cfg_next;
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path: one cycle from address to data
    // ------------------------------------------------------------------------
    wire [7:0]  ra      = {s_axi_araddr[7:2], 2'b00};
    wire        ar_hs   = s_axi_arvalid && s_axi_arready;
    wire [31:0] st_word = {27'h0, armed_reg, !cur_lat.ok, t_running, dqs_reg, dq_reg};
    wire        rd_hit  = (ra == `DTC_ADDR_TERM_MODE) || (ra == `DTC_ADDR_LINK_CFG) || (ra == `DTC_ADDR_STATUS);
    wire [31:0] rd_word = (ra == `DTC_ADDR_TERM_MODE) ? {29'h0, term_mode_reg} :
                          (ra == `DTC_ADDR_LINK_CFG)  ? {26'h0, cfg_reg} :
                          (ra == `DTC_ADDR_STATUS)    ? st_word : 32'h0000_0000;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `DTC_RESP_OKAY;
        end else begin
            rvalid_reg <= ar_hs || (rvalid_reg && !s_axi_rready);
            rdata_reg  <= ar_hs ? rd_word : rdata_reg;
            rresp_reg  <= ar_hs ? (rd_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR) : rresp_reg;
        end
    end

    // ------------------------------------------------------------------------
    // latency selection from band, set and burst length
    // ------------------------------------------------------------------------
    wire [8:0]  sh      = 9'(cfg_reg.band) * 9'd6;
    wire [47:0] on_tbl  = cfg_reg.set_b ? `DTC_LON_B_TBL : `DTC_LON_A_TBL;
    wire [47:0] off_tbl = cfg_reg.set_b ? `DTC_LOFF_B_TBL : `DTC_LOFF_A_TBL;
    wire [5:0]  on_sel  = 6'(on_tbl >> sh);
    wire [5:0]  off_sel = 6'(off_tbl >> sh);
    // zero entries mark bands with no termination support
    assign cur_lat.ok      = (on_sel != 6'h00);
    assign cur_lat.on_lat  = on_sel;
    assign cur_lat.off_lat = cfg_reg.bl32 ? off_sel + `DTC_BL32_EXTRA : off_sel;

    // ------------------------------------------------------------------------
    // write command arms, second cas starts the latency count
    // ------------------------------------------------------------------------
    wire mode_on   = (term_mode_reg != 3'h0);
    wire t_start   = cas2_cmd && (armed_reg || write_cmd);
    wire armed_nxt = (armed_reg || write_cmd) && !cas2_cmd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_nxt;
        end
    end

    dtc_lat_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (t_start),
        .lat     (cur_lat),
        .window  (win),
        .running (t_running)
    );

    // ------------------------------------------------------------------------
    // lane gating; outputs registered so the pads see no decode glitches
    // ------------------------------------------------------------------------
    wire allowed  = mode_on && !power_down && !(self_refresh && !cke);
    wire dq_next  = allowed && !cfg_reg.wlev && win;
    wire dqs_next = allowed && (cfg_reg.wlev || win);
    wire [2:0] value_next = (dq_next || dqs_next) ? term_mode_reg : 3'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_reg    <= 1'b0;
            dqs_reg   <= 1'b0;
            value_reg <= 3'h0;
        end else begin
            dq_reg    <= dq_next;
            dqs_reg   <= dqs_next;
            value_reg <= value_next;
        end
    end

    // mask/inversion lanes share the data-lane control
    assign dq_term_en        = dq_reg;
    assign dmi_term_en       = dq_reg;
    assign dqs_term_en       = dqs_reg;
    assign termination_value = value_reg;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    zero_mode_off_a: assert property (term_mode_reg == 3'h0 |=> !dq_term_en && !dqs_term_en)
        else $error("termination on with zero mode field");
    value_code_a: assert property (dq_term_en |-> termination_value == $past(term_mode_reg))
        else $error("termination value code does not follow mode field");
    idle_highz_a: assert property (!win && !cfg_reg.wlev |=> !dq_term_en && !dqs_term_en)
        else $error("termination on outside a write window");
    on_latency_a: assert property ((t_start && cur_lat.ok && cur_lat.on_lat == 6'h04) ##1
                                   (allowed && !cfg_reg.wlev && !t_start) [*4] |=> dq_term_en)
        else $error("termination not on four clocks after second cas");
    early_on_a: assert property ((t_start && cur_lat.on_lat == 6'h04) ##1 !t_start [*3] |=> !dq_term_en)
        else $error("termination on before turn-on latency");
    off_after_burst_a: assert property ($fell(t_running) |=> !dq_term_en)
        else $error("termination still on after burst completed");
    unsup_band_a: assert property (cfg_reg.band < 3'h2 || (cfg_reg.band == 3'h2 && !cfg_reg.set_b)
                                   |-> !cur_lat.ok)
        else $error("latency reported supported for an unsupported band");
    bl32_extra_a: assert property (cfg_reg.bl32 && cur_lat.ok |-> cur_lat.off_lat == off_sel + 6'h08)
        else $error("32-beat burst turn-off latency wrong");
    pd_off_a: assert property (power_down |=> !dq_term_en && !dqs_term_en)
        else $error("termination on in power-down");
    sr_cke_low_a: assert property (self_refresh && !cke |=> !dqs_term_en)
        else $error("termination on in self refresh with cke low");
    wlev_lanes_a: assert property (cfg_reg.wlev && allowed |=> dqs_term_en && !dq_term_en)
        else $error("write-leveling lane termination wrong");

    write_burst_c: cover property (t_start ##[1:60] $fell(dq_term_en));
    back_to_back_c: cover property (t_start && t_running);
    wlev_dqs_c: cover property (cfg_reg.wlev && dqs_term_en);

endmodule // dtc_term_ctrl

// ### bench/dtc_ctrl_model.sv
// command-side controller model: one write command, then its second cas
`timescale 1ns/100ps

module dtc_ctrl_model
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // request from the bench
    input  wire logic       go,
    input  wire logic [3:0] gap,
    // decoded commands towards the block
    output logic            write_cmd,
    output logic            cas2_cmd
);
    logic       busy_reg;
    logic [3:0] cnt_reg;

    // --------------------------------------------------------------------
    // command sequencer
    // --------------------------------------------------------------------
    // write first, second cas gap+1 clocks later, so spacing varies per call
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            write_cmd <= 1'b0;
            cas2_cmd  <= 1'b0;
            busy_reg  <= 1'b0;
            cnt_reg   <= 4'h0;
        end else begin
            write_cmd <= go && !busy_reg;
            cas2_cmd  <= 1'b0;
            if (go && !busy_reg) begin
                busy_reg <= 1'b1;
                cnt_reg  <= gap;
            end else if (busy_reg) begin
                if (cnt_reg == 4'h0) begin
                    cas2_cmd <= 1'b1;
                    busy_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            end
        end
    end
endmodule // dtc_ctrl_model

// ### bench/dtc_term_ctrl_tb.sv
// self-checking bench for the termination control block
`timescale 1ns/100ps
`include "dtc_params.svh"

module dtc_term_ctrl_tb import dtc_pkg::*;;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, cke, pdn, sref;
    logic        awready, wready, bvalid, arready, rvalid, wr_cmd, cas2, dq_en, dqs_en, dmi_en;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, gap;
    logic [1:0]  bresp, rresp;
    logic [2:0]  tval;
    int          fail_count, total_checks;
    // latencies per band, 0 where the band is unsupported
    int          on_a[8]  = '{0, 0, 0, 4, 4, 6, 6, 8};
    int          on_b[8]  = '{0, 0, 6, 12, 14, 18, 20, 24};
    int          off_a[8] = '{0, 0, 0, 20, 22, 24, 26, 28};
    int          off_b[8] = '{0, 0, 22, 28, 32, 36, 40, 44};

    dtc_term_ctrl dtc_term_ctrl_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .write_cmd(wr_cmd), .cas2_cmd(cas2), .cke(cke), .power_down(pdn), .self_refresh(sref),
        .dq_term_en(dq_en), .dqs_term_en(dqs_en), .dmi_term_en(dmi_en), .termination_value(tval)
    );

    dtc_ctrl_model dtc_ctrl_model_i (
        .aclk(aclk), .aresetn(aresetn), .go(go), .gap(gap), .write_cmd(wr_cmd), .cas2_cmd(cas2)
    );

    // ------------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a wait that runs out counts as a mismatch and closes the run
    task automatic hung(input string name);
        fail_count++;
        $display("[ERR] %s expected answer seen timeout", name);
        tally_and_finish();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 20) hung("bvalid");
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 20) hung("rvalid");
        rready <= 1'b0;
        chk("rdata", rdata, ed);
        chk("rresp", rresp, er);
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // one write burst; measures rise and fall counted from the second cas edge
    task automatic run_burst(input dtc_cfg_t c, input logic [2:0] mode, input logic gated);
        int k, on_t, off_t, e_on, e_off;
        e_on = c.set_b ? on_b[c.band] : on_a[c.band];
        e_off = (c.set_b ? off_b[c.band] : off_a[c.band]) + (c.bl32 ? 8 : 0);
        if (e_on == 0 || mode == 3'h0 || gated) begin
            e_on = -1;
            e_off = -1;
        end
        on_t = -1;
        off_t = -1;
        axi_wr(`DTC_ADDR_LINK_CFG, {26'h0, c}, 2'h0);
        axi_wr(`DTC_ADDR_TERM_MODE, {29'h0, mode}, 2'h0);
        chk("dq idle", dq_en, 32'h0);
        @(posedge aclk);
        go <= 1'b1;
        gap <= {1'b0, c.band};
        @(posedge aclk);
        go <= 1'b0;
        for (k = 0; k < 30 && !cas2; k++) begin
            @(posedge aclk);
            #1;
        end
        if (k == 30) hung("cas2");
        for (k = 0; k < 64; k++) begin
            @(posedge aclk);
            #1;
            if (dq_en && on_t < 0) begin
                on_t = k;
                chk("value", tval, {29'h0, mode});
                chk("dmi", dmi_en, 32'h1);
                chk("dqs", dqs_en, 32'h1);
            end
            if (!dq_en && on_t >= 0 && off_t < 0) off_t = k;
        end
        chk("on latency", on_t, e_on);
        chk("off latency", off_t, e_off);
    endtask

    task automatic reg_access();
        axi_rd(`DTC_ADDR_TERM_MODE, 32'h0, 2'h0);
        axi_rd(`DTC_ADDR_LINK_CFG, 32'h0, 2'h0);
        axi_rd(`DTC_ADDR_STATUS, 32'h8, 2'h0);
        axi_rd(8'h0C, 32'h0, 2'h2);
        axi_wr(8'h0C, 32'hFFFFFFFF, 2'h2);
        axi_wr(`DTC_ADDR_TERM_MODE, 32'hFFFFFFFF, 2'h0);
        axi_rd(`DTC_ADDR_TERM_MODE, 32'h7, 2'h0);
    endtask

    // every band and set at burst length 16, codes 1..6 spread over them, then two 32-beat bursts
    task automatic table_sweep();
        int b, s;
        for (b = 0; b < 8; b++) begin
            for (s = 0; s < 2; s++) begin
                run_burst({2'h0, s[0], b[2:0]}, 3'((2 * b + s) % 6 + 1), 1'b0);
            end
        end
        run_burst({2'h1, 1'b0, 3'h7}, 3'h6, 1'b0);
        run_burst({2'h1, 1'b1, 3'h2}, 3'h1, 1'b0);
    endtask

    task automatic gating();
        run_burst({3'h0, 3'h3}, 3'h0, 1'b0);
        @(posedge aclk);
        pdn <= 1'b1;
        run_burst({3'h0, 3'h3}, 3'h2, 1'b1);
        @(posedge aclk);
        pdn <= 1'b0;
        sref <= 1'b1;
        cke <= 1'b0;
        run_burst({3'h1, 3'h4}, 3'h3, 1'b1);
        @(posedge aclk);
        cke <= 1'b1;
        run_burst({3'h1, 3'h4}, 3'h4, 1'b0);
        @(posedge aclk);
        sref <= 1'b0;
    endtask

    // strobe lanes follow the mode field, data and mask lanes stay off
    task automatic wlev_check();
        int m;
        for (m = 0; m < 2; m++) begin
            axi_wr(`DTC_ADDR_LINK_CFG, {26'h0, 6'h23}, 2'h0);
            axi_wr(`DTC_ADDR_TERM_MODE, m[0] ? 32'h5 : 32'h0, 2'h0);
            repeat (3) @(posedge aclk);
            #1;
            chk("wl dqs", dqs_en, {31'h0, m[0]});
            chk("wl dq", dq_en, 32'h0);
            chk("wl dmi", dmi_en, 32'h0);
        end
        run_burst({3'h4, 3'h3}, 3'h5, 1'b1);
        chk("wl dqs hold", dqs_en, 32'h1);
    endtask

    // ------------------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, go, pdn, sref} = 9'h0;
        cke = 1'b1;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        gap = 4'h0;
        fail_count = 0;
        total_checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk("reset dq", {dq_en, dqs_en, dmi_en, tval}, 32'h0);
        reg_access();
        table_sweep();
        gating();
        wlev_check();
        tally_and_finish();
    end
endmodule // dtc_term_ctrl_tb
